// ---- hdl/acl_consts.svh ----
// Purpose: Named constants of the per-port access control list filter.
// Assumes: 20 MHz clock; register word index on an 8-bit address.
// Notes:   Definitions only.
`ifndef ACL_CONSTS_SVH
`define ACL_CONSTS_SVH

// ----------------------------------------------------------------
// Table size and counting
// ----------------------------------------------------------------
`define ACL_ENTRIES   16
`define ACL_CNT_W     11
`define ACL_CLK_NS    50
`define ACL_US_NS     1000
`define ACL_US_CYC    (`ACL_US_NS / `ACL_CLK_NS)
`define ACL_MS_US     1000

// ----------------------------------------------------------------
// Register map: table words at {1'b0, entry[3:0], word[2:0]}
// ----------------------------------------------------------------
`define ACL_W_MCTL    3'h0
`define ACL_W_MLO     3'h1
`define ACL_W_MHI     3'h2
`define ACL_W_MASK    3'h3
`define ACL_W_ACT     3'h4
`define ACL_W_PROC    3'h5
`define ACL_W_CSTAT   3'h6
`define ACL_A_CTRL    8'h80
`define ACL_A_EVENT   8'h81
`define ACL_A_LAST    8'h82

// ----------------------------------------------------------------
// Option codes per layer
// ----------------------------------------------------------------
`define ACL_L2_COUNT  2'h0
`define ACL_L2_TYPE   2'h1
`define ACL_L2_MAC    2'h2
`define ACL_L2_BOTH   2'h3
`define ACL_L3_MASKED 2'h1
`define ACL_L3_PAIR   2'h2
`define ACL_L4_PROTO  2'h0
`define ACL_L4_TCP    2'h1
`define ACL_L4_UDP    2'h2
`define ACL_L4_SEQ    2'h3

`endif

// ---- hdl/acl_pkg.sv ----
// Purpose: Types shared by the access control list filter.
// Assumes: acl_consts.svh holds the numbers.
// Notes:   Structs pack into the register words directly.
package acl_pkg;

  typedef enum logic [1:0] {
    ACL_L_OFF = 2'b00,
    ACL_L_MAC = 2'b01,
    ACL_L_IP  = 2'b10,
    ACL_L_L4  = 2'b11
  } acl_layer_type;

  typedef struct packed {
    logic          equality_sense;
    logic          src_dst;
    logic [1:0]    match_option_select;
    acl_layer_type match_layer_select;
  } acl_mctl_type;

  typedef struct packed {
    acl_mctl_type ctl;
    logic [31:0]  lo;
    logic [15:0]  hi;
    logic [15:0]  etype;
    logic [31:0]  mask;
  } acl_rule_type;

  typedef struct packed {
    logic [15:0] code;
    logic [2:0]  rsvd;
    logic        count_algorithm;
    logic        count_time_unit;
    logic [10:0] count;
  } acl_act_type;

  typedef struct packed {
    logic [15:0] rule_select_mask;
    logic [11:0] rsvd;
    logic [3:0]  action_rule_pointer;
  } acl_proc_type;

  typedef struct packed {
    logic        valid;
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [15:0] etype;
    logic        is_ip;
    logic [31:0] sip;
    logic [31:0] dip;
    logic [7:0]  proto;
    logic        is_tcp;
    logic        is_udp;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [31:0] seq;
  } acl_pkt_type;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [3:0]  ptr;
    logic [15:0] code;
  } acl_result_type;

endpackage

// ---- hdl/acl_match.sv ----
// Purpose: One matching rule compared against one parsed header.
// Assumes: Header fields are stable while valid is high.
// Notes:   Purely combinational; one instance per table entry.
`timescale 1ns/1ps
`include "acl_consts.svh"

module acl_match (
  // Rule and header
  input  wire acl_pkg::acl_rule_type rule,
  input  wire acl_pkg::acl_pkt_type  pkt,
  // Results
  output logic                       hit,
  output logic                       cnt_hit
);
  import acl_pkg::*;

  logic [47:0] mac;
  logic [31:0] ip;
  logic [15:0] port;
  logic        mac_eq;
  logic        type_eq;
  logic        usable;
  logic        equal;

  assign mac     = rule.ctl.src_dst ? pkt.smac : pkt.dmac;
  assign ip      = rule.ctl.src_dst ? pkt.sip : pkt.dip;
  assign port    = rule.ctl.src_dst ? pkt.sport : pkt.dport;
  assign mac_eq  = (mac == {rule.hi, rule.lo});
  assign type_eq = (pkt.etype == rule.etype);

  always_comb
  begin
    usable  = 1'b0;
    equal   = 1'b0;
    cnt_hit = 1'b0;
    unique case (rule.ctl.match_layer_select)
      ACL_L_OFF:
      begin
        usable = 1'b0;
      end
      ACL_L_MAC:
      begin
        case (rule.ctl.match_option_select)
          `ACL_L2_COUNT: cnt_hit = mac_eq && type_eq;
          `ACL_L2_TYPE:  begin usable = 1'b1; equal = type_eq; end
          `ACL_L2_MAC:   begin usable = 1'b1; equal = mac_eq; end
          default:       begin usable = 1'b1; equal = mac_eq && type_eq; end
        endcase
      end
      ACL_L_IP:
      begin
        // Reserved options never match, so a stray code cannot pass traffic
        case (rule.ctl.match_option_select)
          `ACL_L3_MASKED:
          begin
            usable = pkt.is_ip;
            equal  = (((ip ^ rule.lo) & ~rule.mask) == 32'h0000_0000);
          end
          `ACL_L3_PAIR:
          begin
            usable = pkt.is_ip;
            equal  = (pkt.sip == rule.lo) && (pkt.dip == rule.mask);
          end
          default: usable = 1'b0;
        endcase
      end
      ACL_L_L4:
      begin
        case (rule.ctl.match_option_select)
          `ACL_L4_PROTO: begin usable = pkt.is_ip; equal = pkt.proto == rule.lo[7:0]; end
          `ACL_L4_TCP:   begin usable = pkt.is_tcp; equal = port == rule.lo[15:0]; end
          `ACL_L4_UDP:   begin usable = pkt.is_udp; equal = port == rule.lo[15:0]; end
          default:       begin usable = pkt.is_tcp; equal = pkt.seq == rule.lo; end
        endcase
      end
    endcase
  end

  // Sense applies only to a real comparison; disabled rules stay false
  assign hit = usable && (rule.ctl.equality_sense ? equal : !equal);

endmodule

// ---- hdl/acl_filter.sv ----
// Purpose: Per-port ingress access control list with 16 entries.
// Assumes: Header fields come from parse logic on the same clock.
// Notes:   Result is registered one cycle after the header strobe.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "acl_consts.svh"

module acl_filter #(
  parameter int MS_US = `ACL_MS_US
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // Register port
  input  wire logic [7:0]             addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [31:0]            rdata,
  // Parsed header in, verdict out
  input  wire acl_pkg::acl_pkt_type   pkt,
  output acl_pkg::acl_result_type     result,
  // Count events, one pulse per entry
  output logic      [15:0]            count_event
);
  import acl_pkg::*;

  localparam int N         = `ACL_ENTRIES;
  localparam int US_CYC_I  = `ACL_US_CYC;
  localparam int CW        = `ACL_CNT_W;

  // ----------------------------------------------------------------
  // Table storage
  // ----------------------------------------------------------------
  acl_rule_type   rule_q [N];
  acl_act_type    act_q  [N];
  acl_proc_type   proc_q [N];
  logic [CW-1:0]  cnt_q  [N];
  logic [N-1:0]   armed_q;
  logic [N-1:0]   fire_q;
  logic [N-1:0]   event_q;
  logic           enable_q;
  acl_result_type result_q;
  logic [31:0]    rdata_q;
  logic [4:0]     last_q;

  logic           tab_sel;
  logic [3:0]     ent;
  logic [N-1:0]   match_vec;
  logic [N-1:0]   cnt_vec;
  logic [N-1:0]   counting;
  logic [N-1:0]   set_true;
  logic [N-1:0]   act_hit;
  logic [3:0]     sel_ptr;
  logic           any_hit;
  logic [31:0]    rd_d;

  assign tab_sel = !addr[7];
  assign ent     = addr[6:3];

  // ----------------------------------------------------------------
  // Time base: 1 us enable, and 1 ms enable from it
  // ----------------------------------------------------------------
  logic [4:0] us_cnt_q;
  logic [9:0] ms_cnt_q;
  logic       us_tick;
  logic       ms_tick;

  assign us_tick = (us_cnt_q == 5'(US_CYC_I - 1));
  assign ms_tick = us_tick && (ms_cnt_q == 10'(MS_US - 1));

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      us_cnt_q <= 5'h00;
    else if (us_tick)
      us_cnt_q <= 5'h00;
    else
      us_cnt_q <= us_cnt_q + 5'h01;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ms_cnt_q <= 10'h000;
    else if (ms_tick)
      ms_cnt_q <= 10'h000;
    else if (us_tick)
      ms_cnt_q <= ms_cnt_q + 10'h001;
  end

  us_period_a: assert property (@(posedge clock) disable iff (!rstn)
    us_tick |-> ##US_CYC_I us_tick)
    else $error("microsecond tick period wrong");

  // ----------------------------------------------------------------
  // Per-entry table, comparator and counter
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_ent
      logic wsel;
      logic tick;
      assign wsel = wr && tab_sel && (ent == 4'(i));

      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
        begin
          rule_q[i] <= '0;
          act_q[i]  <= '0;
          proc_q[i] <= '0;
        end
        else if (wsel)
        begin
          unique case (addr[2:0])
            `ACL_W_MCTL: rule_q[i].ctl <= acl_mctl_type'(wdata[5:0]);
            `ACL_W_MLO:  rule_q[i].lo  <= wdata;
            `ACL_W_MHI:  {rule_q[i].etype, rule_q[i].hi} <= wdata;
            `ACL_W_MASK: rule_q[i].mask <= wdata;
            `ACL_W_ACT:  act_q[i] <= acl_act_type'({wdata[31:16], 3'h0, wdata[12:0]});
            `ACL_W_PROC: proc_q[i] <= acl_proc_type'({wdata[31:16], 12'h000, wdata[3:0]});
            default:     ;
          endcase
        end
      end

      acl_match u_match (
        .rule    (rule_q[i]),
        .pkt     (pkt),
        .hit     (match_vec[i]),
        .cnt_hit (cnt_vec[i])
      );

      assign counting[i] = (rule_q[i].ctl.match_layer_select == ACL_L_MAC) &&
                           (rule_q[i].ctl.match_option_select == `ACL_L2_COUNT);

      // AND of the selected matches; an empty mask selects nothing
      assign set_true[i] = pkt.valid && (proc_q[i].rule_select_mask != 16'h0000) &&
        ((match_vec & proc_q[i].rule_select_mask) ==
         proc_q[i].rule_select_mask);

      assign tick = act_q[i].count_time_unit ? ms_tick : us_tick;

      // Count value lives in the action word of this same index
      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
        begin
          cnt_q[i]   <= '0;
          armed_q[i] <= 1'b0;
          fire_q[i]  <= 1'b0;
        end
        else if (!counting[i])
        begin
          cnt_q[i]   <= '0;
          armed_q[i] <= 1'b0;
          fire_q[i]  <= 1'b0;
        end
        else if (act_q[i].count_algorithm)
        begin
          armed_q[i] <= 1'b0;
          fire_q[i]  <= 1'b0;
          if (pkt.valid && cnt_vec[i])
          begin
            if (({1'b0, cnt_q[i]} + 12'h001) >= {1'b0, act_q[i].count})
            begin
              cnt_q[i]  <= '0;
              fire_q[i] <= 1'b1;
            end
            else
              cnt_q[i] <= cnt_q[i] + 11'h001;
          end
        end
        else
        begin
          fire_q[i] <= 1'b0;
          // A qualifying packet restarts the window before a tick can expire it
          if (pkt.valid && cnt_vec[i])
          begin
            cnt_q[i]   <= act_q[i].count;
            armed_q[i] <= 1'b1;
          end
          else if (armed_q[i] && tick)
          begin
            if (cnt_q[i] <= 11'h001)
            begin
              cnt_q[i]   <= '0;
              armed_q[i] <= 1'b0;
              fire_q[i]  <= 1'b1;
            end
            else
              cnt_q[i] <= cnt_q[i] - 11'h001;
          end
        end
      end

      disabled_rule_a: assert property (@(posedge clock) disable iff (!rstn)
        (rule_q[i].ctl.match_layer_select == ACL_L_OFF) |-> !match_vec[i])
        else $error("disabled rule produced a match");

      watchdog_fire_a: assert property (@(posedge clock) disable iff (!rstn)
        (fire_q[i] && !act_q[i].count_algorithm) |->
          ($past(armed_q[i]) && !armed_q[i] && (cnt_q[i] == 11'h000)))
        else $error("watchdog fired without expiry");

      event_fire_a: assert property (@(posedge clock) disable iff (!rstn)
        (fire_q[i] && act_q[i].count_algorithm) |->
          ($past(cnt_vec[i] && pkt.valid) && (cnt_q[i] == 11'h000)))
        else $error("event counter fired or reset wrongly");

      set_action_a: assert property (@(posedge clock) disable iff (!rstn)
        (set_true[i] && enable_q && !counting[proc_q[i].action_rule_pointer]) |=>
          (result_q.hit && (result_q.ptr <= $past(proc_q[i].action_rule_pointer))))
        else $error("true rule set lost its action");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Action selection
  // ----------------------------------------------------------------
  always_comb
  begin
    act_hit = '0;
    for (int k = 0; k < N; k++)
    begin
      if (set_true[k])
        act_hit[proc_q[k].action_rule_pointer] = 1'b1;
    end
    act_hit = act_hit & ~counting;
  end

  always_comb
  begin
    sel_ptr = 4'h0;
    for (int k = N - 1; k >= 0; k--)
    begin
      if (act_hit[k])
        sel_ptr = 4'(k);
    end
  end

  assign any_hit = |act_hit;

  // Each port owns an instance, so rules never see another port's traffic
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      result_q <= '0;
    else
    begin
      result_q.valid <= pkt.valid;
      result_q.hit   <= pkt.valid && enable_q && any_hit;
      result_q.ptr   <= sel_ptr;
      result_q.code  <= act_q[sel_ptr].code;
    end
  end

  assign result = result_q;

  no_action_a: assert property (@(posedge clock) disable iff (!rstn)
    (pkt.valid && (act_hit == 16'h0000)) |=> (result_q.valid && !result_q.hit))
    else $error("action applied with no true rule set");

  first_entry_a: assert property (@(posedge clock) disable iff (!rstn)
    (pkt.valid && enable_q && act_hit[0]) |=> (result_q.hit && (result_q.ptr == 4'h0)))
    else $error("entry zero did not win");

  lowest_ptr_a: assert property (@(posedge clock) disable iff (!rstn)
    result_q.hit |-> (($past(act_hit) & ((16'h0001 << result_q.ptr) - 16'h0001)) == 16'h0000
                      && ($past(act_hit) & (16'h0001 << result_q.ptr)) != 16'h0000))
    else $error("action was not the lowest true pointer");

  count_no_action_a: assert property (@(posedge clock) disable iff (!rstn)
    result_q.hit |-> (($past(counting) & (16'h0001 << result_q.ptr)) == 16'h0000))
    else $error("counting entry used as action");

  // ----------------------------------------------------------------
  // Global control, event flags and readback
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      enable_q <= 1'b0;
    else if (wr && (addr == `ACL_A_CTRL))
      enable_q <= wdata[0];
  end

  // A count event in the clearing cycle stays set
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      event_q <= '0;
    else if (wr && (addr == `ACL_A_EVENT))
      event_q <= (event_q & ~wdata[15:0]) | fire_q;
    else
      event_q <= event_q | fire_q;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      last_q <= 5'h00;
    else if (result_q.valid)
      last_q <= {result_q.hit, result_q.ptr};
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (tab_sel)
    begin
      unique case (addr[2:0])
        `ACL_W_MCTL:  rd_d = {26'h0, rule_q[ent].ctl};
        `ACL_W_MLO:   rd_d = rule_q[ent].lo;
        `ACL_W_MHI:   rd_d = {rule_q[ent].etype, rule_q[ent].hi};
        `ACL_W_MASK:  rd_d = rule_q[ent].mask;
        `ACL_W_ACT:   rd_d = act_q[ent];
        `ACL_W_PROC:  rd_d = proc_q[ent];
        `ACL_W_CSTAT: rd_d = {20'h0, armed_q[ent], cnt_q[ent]};
        default:      rd_d = 32'h0000_0000;
      endcase
    end
    else if (addr == `ACL_A_CTRL)
      rd_d = {31'h0, enable_q};
    else if (addr == `ACL_A_EVENT)
      rd_d = {16'h0, event_q};
    else if (addr == `ACL_A_LAST)
      rd_d = {27'h0, last_q};
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 32'h0000_0000;
    else if (rd)
      rdata_q <= rd_d;
    else
      rdata_q <= 32'h0000_0000;
  end

  assign rdata       = rdata_q;
  assign count_event = fire_q;

endmodule

// ---- bench/acl_parser_model.sv ----
// Purpose: Ingress parser stand-in that feeds parsed headers to the filter.
// Assumes: One header per send request, same clock as the filter.
// Notes:   Fields are inverted every idle cycle so stale values never look valid.
`timescale 1ns/1ps

module acl_parser_model
  import acl_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // Request from the bench
  input  wire logic                 send,
  input  wire acl_pkg::acl_pkt_type hdr,
  // Parsed header to the filter
  output acl_pkg::acl_pkt_type      pkt
);
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      pkt <= '0;
    else if (send)
      pkt <= {1'b1, hdr[$bits(acl_pkt_type)-2:0]};
    else
      pkt <= {1'b0, ~pkt[$bits(acl_pkt_type)-2:0]};
endmodule

// ---- bench/acl_filter_tb_top.sv ----
// Purpose: Self-checking bench for the access control list filter.
// Assumes: Millisecond tick shortened to two microsecond ticks.
// Notes:   Counter pulses are collected in a sticky vector.
`timescale 1ns/1ps

module acl_filter_tb_top;
  import acl_pkg::*;
  localparam logic [47:0] M1 = 48'h0200_0000_0001;
  localparam logic [47:0] M2 = 48'h0200_0000_0002;
  localparam logic [15:0] ET = 16'h0800;
  localparam logic [15:0] E2 = 16'h88b5;
  logic           clock = 1'b0;
  logic           rstn = 1'b0;
  logic [7:0]     addr = 8'h00;
  logic [31:0]    wdata = 32'h0;
  logic           wr = 1'b0;
  logic           rd = 1'b0;
  logic           send = 1'b0;
  logic           ev_clr = 1'b1;
  logic [31:0]    rdata;
  logic [31:0]    got;
  logic [15:0]    count_event;
  logic [15:0]    ev_seen;
  acl_pkt_type    hdr = '0;
  acl_pkt_type    pkt;
  acl_result_type result;
  int             n_errors = 0;
  int             total_checks = 0;

  always #25 clock = ~clock;
  always @(posedge clock)
    ev_seen <= ev_clr ? 16'h0 : (ev_seen | count_event);

  acl_filter #(.MS_US(2)) i_acl_filter (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pkt(pkt), .result(result), .count_event(count_event));
  acl_parser_model i_acl_parser_model (
    .clock(clock), .rstn(rstn), .send(send), .hdr(hdr), .pkt(pkt));

  task summarize;
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task rule(input logic [3:0] e, input logic [7:0] c, input logic [31:0] lo,
            input logic [31:0] hi, input logic [31:0] m);
    wr_reg({1'b0, e, 3'h0}, {24'h0, c});
    wr_reg({1'b0, e, 3'h1}, lo);
    wr_reg({1'b0, e, 3'h2}, hi);
    wr_reg({1'b0, e, 3'h3}, m);
  endtask

  // Send one header; a hit compares pointer and code, a miss only valid/hit
  task xp(input logic [47:0] mac, input logic [15:0] et, input logic [31:0] dip,
          input logic [31:0] dp, input logic h, input logic [3:0] p,
          input logic [15:0] c);
    acl_pkt_type    q;
    acl_result_type r;
    q       = '0;
    q.valid = 1'b1;
    q.dmac  = mac;
    q.etype = et;
    q.is_ip = 1'b1;
    q.dip   = dip;
    q.is_tcp = 1'b1;
    q.dport = dp[15:0];
    @(posedge clock);
    hdr  <= q;
    send <= 1'b1;
    @(posedge clock);
    send <= 1'b0;
    @(posedge clock);
    #1 r = result;
    if (h)
      chk({10'h0, r.valid, r.hit, r.ptr, r.code}, {10'h0, 2'b11, p, c});
    else
      chk({30'h0, r.valid, r.hit}, 32'h2);
  endtask

  // Watchdog: silent before the earliest tick, fired by the latest
  task wdog(input logic [31:0] act, input int early, input int late);
    wr_reg(8'h24, act);
    ev_clr <= 1'b1;
    repeat (60) @(posedge clock);
    ev_clr <= 1'b0;
    repeat (60) @(posedge clock);
    chk({16'h0, ev_seen}, 32'h0);
    xp(M2, E2, 0, 0, 1'b0, 4'h0, 16'h0);
    repeat (early) @(posedge clock);
    chk({16'h0, ev_seen}, 32'h0);
    repeat (late) @(posedge clock);
    chk({16'h0, ev_seen}, 32'h10);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    rd_reg(8'h05, got);
    chk(got, 32'h0);
    wr_reg(8'h05, 32'h0001_0002);
    rd_reg(8'h05, got);
    chk(got, 32'h0001_0002);
    wr_reg(8'h83, 32'hffff_ffff);
    rd_reg(8'h83, got);
    chk(got, 32'h0);
    wr_reg(8'h80, 32'h1);
    wr_reg(8'h04, 32'h3333_0000);
    wr_reg(8'h0c, 32'h2222_0000);
    wr_reg(8'h14, 32'h1111_0000);
    rule(4'h0, 8'h29, M1[31:0], {ET, M1[47:32]}, 32'h0);
    xp(M1, E2, 0, 0, 1'b1, 4'h2, 16'h1111);
    xp(M2, E2, 0, 0, 1'b0, 4'h0, 16'h0);
    rule(4'h1, 8'h25, 32'h0, {ET, 16'h0}, 32'h0);
    wr_reg(8'h0d, 32'h0002_0001);
    xp(M1, ET, 0, 0, 1'b1, 4'h1, 16'h2222);
    wr_reg(8'h15, 32'h0003_0000);
    xp(M1, ET, 0, 0, 1'b1, 4'h0, 16'h3333);
    xp(M1, E2, 0, 0, 1'b1, 4'h2, 16'h1111);
    wr_reg(8'h15, 32'h0);
    wr_reg(8'h0d, 32'h0002_0002);
    xp(M2, ET, 0, 0, 1'b1, 4'h2, 16'h1111);
    wr_reg(8'h08, 32'h05);
    xp(M2, E2, 0, 0, 1'b1, 4'h2, 16'h1111);
    xp(M2, ET, 0, 0, 1'b0, 4'h0, 16'h0);
    wr_reg(8'h3c, 32'h7777_0000);
    wr_reg(8'h4c, 32'h9999_0000);
    rule(4'h5, 8'h27, 32'h50, 32'h0, 32'h0);
    wr_reg(8'h2d, 32'h0020_0007);
    xp(M2, ET, 0, 32'h0000_0050, 1'b1, 4'h7, 16'h7777);
    xp(M2, ET, 0, 32'h0000_0051, 1'b0, 4'h0, 16'h0);
    rule(4'h6, 8'h26, 32'h0a00_0001, 32'h0, 32'h0000_00ff);
    wr_reg(8'h35, 32'h0040_0009);
    xp(M2, ET, 32'h0a00_00ee, 0, 1'b1, 4'h9, 16'h9999);
    xp(M2, ET, 32'h0b00_00ee, 0, 1'b0, 4'h0, 16'h0);
    wr_reg(8'h30, 32'h24);
    xp(M2, ET, 32'h0a00_00ee, 0, 1'b0, 4'h0, 16'h0);
    // Event counter on entry 3, its pointer must never apply
    // Entry 1 (type unequal) stays true and now only selects the counting pointer
    wr_reg(8'h0d, 32'h0);
    rule(4'h3, 8'h01, M2[31:0], {16'h88f7, M2[47:32]}, 32'h0);
    wr_reg(8'h1c, 32'h3333_1003);
    wr_reg(8'h1d, 32'h0002_0003);
    ev_clr <= 1'b0;
    repeat (2) xp(M2, 16'h88f7, 0, 0, 1'b0, 4'h0, 16'h0);
    repeat (3) @(posedge clock);
    chk({16'h0, ev_seen}, 32'h0);
    xp(M2, 16'h88f7, 0, 0, 1'b0, 4'h0, 16'h0);
    repeat (3) @(posedge clock);
    chk({16'h0, ev_seen}, 32'h8);
    rd_reg(8'h81, got);
    chk(got, 32'h8);
    wr_reg(8'h81, 32'h8);
    rd_reg(8'h81, got);
    chk(got, 32'h0);
    // Remaining option codes except L4 protocol on entry 6, pointer 9
    rule(4'h6, 8'h2d, M2[31:0], {ET, M2[47:32]}, 32'h0);
    xp(M2, ET, 0, 0, 1'b1, 4'h9, 16'h9999);
    xp(M2, E2, 0, 0, 1'b0, 4'h0, 16'h0);
    rule(4'h6, 8'h2a, 32'h0, 32'h0, 32'h0a00_0005);
    xp(M2, ET, 32'h0a00_0005, 0, 1'b1, 4'h9, 16'h9999);
    xp(M2, ET, 32'h0a00_0004, 0, 1'b0, 4'h0, 16'h0);
    rule(4'h6, 8'h2b, 32'h60, 32'h0, 32'h0);
    xp(M2, ET, 0, 32'h0000_0060, 1'b0, 4'h0, 16'h0);
    rule(4'h6, 8'h0f, 32'h1, 32'h0, 32'h0);
    xp(M2, ET, 0, 0, 1'b1, 4'h9, 16'h9999);
    rule(4'h6, 8'h39, 32'h0, 32'h0, 32'h0);
    xp(M2, ET, 0, 0, 1'b1, 4'h9, 16'h9999);
    wr_reg(8'h30, 32'h0);
    // Watchdog on entry 4, microsecond then millisecond unit
    rule(4'h4, 8'h01, M2[31:0], {E2, M2[47:32]}, 32'h0);
    wdog(32'h0000_0002, 18, 45);
    wdog(32'h0000_0802, 42, 48);
    summarize;
  end

  initial
  begin
    #(20000 * 50);
    n_errors++;
    summarize;
  end
endmodule
